/* verilog/ssp_consts.svh */
// constants of the sensor serial control port
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_REG_COUNT 128
`define SSP_ADDR_LINES_LO 7'h01
`define SSP_ADDR_LINES_HI 7'h02
`define SSP_ADDR_EXP_LO 7'h2a
`define SSP_ADDR_EXP_MID 7'h2b
`define SSP_ADDR_EXP_HI 7'h2c
`define SSP_ADDR_FRAMES_LO 7'h46
`define SSP_ADDR_FRAMES_HI 7'h47
`define SSP_ADDR_FOT_LEN 7'h49
`define SSP_ADDR_ADC_GAIN 7'h76

`define SSP_LINES_LO_DEFAULT 8'h00
`define SSP_LINES_HI_DEFAULT 8'h08
`define SSP_EXP_LO_DEFAULT 8'h00
`define SSP_EXP_MID_DEFAULT 8'h01
`define SSP_FRAMES_LO_DEFAULT 8'h01
`define SSP_FOT_LEN_DEFAULT 8'h14
`define SSP_GAIN_DEFAULT 8'h20

`define SSP_LINE_CYCLES 24'h000081
`define SSP_FOT_EXTRA 24'h000002
`define SSP_BIT_LAST 4'hf
`define SSP_BIT_ADDR_DONE 4'h8
`define SSP_BIT_FIRST_OUT 4'h9
`define SSP_SYNC_INIT 1'b0

`endif

/* verilog/ssp_pkg.sv */
// types of the sensor serial control port
package ssp_pkg;
  typedef logic [7:0] ssp_byte_t;
  typedef logic [6:0] ssp_addr_t;
  typedef enum logic [3:0] {
    SSP_IDLE = 4'b0001,
    SSP_EXPOSE = 4'b0010,
    SSP_FOT = 4'b0100,
    SSP_READ = 4'b1000
  } ssp_state_t;
endpackage : ssp_pkg

/* verilog/ssp_link.sv */
// serial shift logic on the host serial clock
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_link (
  input wire logic spi_clk_i,
  input wire logic spi_en_i,
  input wire logic spi_in_i,
  input wire logic link_rst_i,
  input wire ssp_pkg::ssp_byte_t rd_data_i,
  output ssp_pkg::ssp_addr_t rd_addr_o,
  output logic spi_out_o,
  output logic wr_toggle_o,
  output ssp_pkg::ssp_addr_t wr_addr_o,
  output ssp_pkg::ssp_byte_t wr_data_o
);
  import ssp_pkg::*;

  logic [3:0] bit_cnt;
  logic [14:0] shift;
  logic pend_t;
  ssp_byte_t out_sh;
  wire wr_frame_end;
  wire rd_load;
  wire rd_shift;

  // control bit one on the sixteenth bit means a write
  assign wr_frame_end = (bit_cnt == `SSP_BIT_LAST) && shift[14];
  assign rd_load = (bit_cnt == `SSP_BIT_ADDR_DONE) && !shift[7];
  assign rd_shift = bit_cnt > `SSP_BIT_ADDR_DONE;
  assign rd_addr_o = shift[6:0];
  assign spi_out_o = out_sh[7];

  // enable low clears the frame state
  always_ff @(posedge spi_clk_i or negedge spi_en_i)
  begin
    if (!spi_en_i)
    begin
      bit_cnt <= 4'h0;
      shift <= 15'h0000;
    end
    else
    begin
      bit_cnt <= bit_cnt + 4'h1;
      shift <= {shift[13:0], spi_in_i};
    end
  end

  always_ff @(posedge spi_clk_i or posedge link_rst_i)
  begin
    if (link_rst_i)
      pend_t <= 1'b0;
    else if (wr_frame_end)
      pend_t <= ~pend_t;
  end

  // address and data stay put until the next write frame ends
  always_ff @(posedge spi_clk_i)
  begin
    if (wr_frame_end)
    begin
      wr_addr_o <= shift[13:7];
      wr_data_o <= {shift[6:0], spi_in_i};
    end
  end

  // write completes on the falling edge after the last bit
  always_ff @(negedge spi_clk_i or posedge link_rst_i)
  begin
    if (link_rst_i)
      wr_toggle_o <= 1'b0;
    else
      wr_toggle_o <= pend_t;
  end

  // read data launched on falling edges, msb first
  always_ff @(negedge spi_clk_i or negedge spi_en_i)
  begin
    if (!spi_en_i)
      out_sh <= 8'h00;
    else if (rd_load)
      out_sh <= rd_data_i;
    else if (rd_shift)
      out_sh <= {out_sh[6:0], 1'b0};
    else
      out_sh <= 8'h00;
  end

  frame_wrap_a: assert property (
    @(posedge spi_clk_i) disable iff (!spi_en_i)
    (bit_cnt == `SSP_BIT_LAST) |=> (bit_cnt == 4'h0))
    else $error("bit counter did not wrap for the next frame");

  read_msb_a: assert property (
    @(posedge spi_clk_i) disable iff (!spi_en_i)
    (bit_cnt == `SSP_BIT_FIRST_OUT && !shift[8])
    |-> ($past(spi_out_o) == $past(rd_data_i[7])))
    else $error("read data msb not on serial output");

  write_capture_a: assert property (
    @(posedge spi_clk_i) disable iff (!spi_en_i || link_rst_i)
    wr_frame_end ##1 (bit_cnt == 4'h0) |-> (wr_data_o[0] == $past(spi_in_i)))
    else $error("write data lsb not captured");

  idle_clear_a: assert property (
    @(negedge spi_clk_i) disable iff (link_rst_i)
    !spi_en_i |-> (bit_cnt == 4'h0 && spi_out_o == 1'b0))
    else $error("frame state kept while enable low");

endmodule : ssp_link

/* verilog/ssp_top.sv */
// sensor control port: register file, sequencer and serial link
// Functional notes
// - serial input sampled on rising serial clock edges; clock at most 48MHz.
// - each access is sixteen bits: control, seven address, eight data.
// - first bit one means write, zero means read.
// - back to back frames while enable stays high write several registers.
// - read data driven on falling edges after the address, msb first.
// - registers 78-79 accept writes at any time without disturbing capture.
// - reset falling edge resets sequencer and all registers to defaults.
// - adc gain defaults to 32 after reset.
// - reset active low, sampled on master clock, held low at start-up.
// - high frame request starts capture of the programmed number of frames.
// - serial transfers happen only while enable is high.
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sensor_reset_n_i,
  input wire logic frame_req_i,
  input wire logic spi_clk_i,
  input wire logic spi_en_i,
  input wire logic spi_in_i,
  output logic spi_out_o,
  output logic busy_o,
  output logic fot_o,
  output logic readout_o,
  output ssp_pkg::ssp_byte_t adc_gain_o
);
  import ssp_pkg::*;

  // power-on values of the register file
  function automatic ssp_byte_t ssp_reg_default(input ssp_addr_t a);
    case (a)
      `SSP_ADDR_LINES_LO: ssp_reg_default = `SSP_LINES_LO_DEFAULT;
      `SSP_ADDR_LINES_HI: ssp_reg_default = `SSP_LINES_HI_DEFAULT;
      `SSP_ADDR_EXP_LO: ssp_reg_default = `SSP_EXP_LO_DEFAULT;
      `SSP_ADDR_EXP_MID: ssp_reg_default = `SSP_EXP_MID_DEFAULT;
      `SSP_ADDR_FRAMES_LO: ssp_reg_default = `SSP_FRAMES_LO_DEFAULT;
      `SSP_ADDR_FOT_LEN: ssp_reg_default = `SSP_FOT_LEN_DEFAULT;
      `SSP_ADDR_ADC_GAIN: ssp_reg_default = `SSP_GAIN_DEFAULT;
      default: ssp_reg_default = 8'h00;
    endcase
  endfunction : ssp_reg_default

  // link side signals
  ssp_addr_t rd_addr;
  ssp_byte_t rd_data;
  logic wr_toggle;
  ssp_addr_t wr_addr;
  ssp_byte_t wr_data;

  ssp_link ssp_link_inst (
    .spi_clk_i(spi_clk_i),
    .spi_en_i(spi_en_i),
    .spi_in_i(spi_in_i),
    .link_rst_i(rst_i),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .spi_out_o(spi_out_o),
    .wr_toggle_o(wr_toggle),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // two-stage synchronisers for pins and the write toggle
  wire [2:0] sync_in;
  logic [2:0] sync_q1;
  logic [2:0] sync_q2;
  assign sync_in = {wr_toggle, frame_req_i, sensor_reset_n_i};

  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync_q1[g] <= `SSP_SYNC_INIT;
          sync_q2[g] <= `SSP_SYNC_INIT;
        end
        else
        begin
          sync_q1[g] <= sync_in[g];
          sync_q2[g] <= sync_q1[g];
        end
      end
    end
  endgenerate

  wire rst_n_s;
  wire frame_req_s;
  wire wr_tog_s;
  assign rst_n_s = sync_q2[0];
  assign frame_req_s = sync_q2[1];
  assign wr_tog_s = sync_q2[2];

  logic wr_tog_d;
  wire wr_evt;
  wire reg_hold;
  assign wr_evt = wr_tog_s ^ wr_tog_d;
  // low reset level, and thus its falling edge, holds defaults
  assign reg_hold = rst_i | ~rst_n_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_tog_d <= 1'b0;
    else
      wr_tog_d <= wr_tog_s;
  end

  // register file
  ssp_byte_t regs [0:`SSP_REG_COUNT-1];

  // no address is gated, so 78-79 take writes in every state
  always_ff @(posedge clk_i)
  begin
    if (reg_hold)
    begin
      for (int i = 0; i < `SSP_REG_COUNT; i++)
        regs[i] <= ssp_reg_default(7'(i));
    end
    else if (wr_evt)
      regs[wr_addr] <= wr_data;
  end

  // read word follows rd_addr as it shifts; the register bytes change only by writes or reset
  assign rd_data = regs[rd_addr];
  assign adc_gain_o = regs[`SSP_ADDR_ADC_GAIN];

  // sequencer timing from the register file
  wire [15:0] frames_raw;
  wire [15:0] frames_total;
  wire [23:0] exp_raw;
  wire [23:0] exp_cycles;
  wire [23:0] fot_cycles;
  wire [23:0] read_cycles;
  assign frames_raw = {regs[`SSP_ADDR_FRAMES_HI], regs[`SSP_ADDR_FRAMES_LO]};
  assign frames_total = (frames_raw == 16'h0000) ? 16'h0001 : frames_raw;
  assign exp_raw = {regs[`SSP_ADDR_EXP_HI], regs[`SSP_ADDR_EXP_MID], regs[`SSP_ADDR_EXP_LO]};
  assign exp_cycles = (exp_raw == 24'h000000) ? 24'h000001 : exp_raw;
  assign fot_cycles = ({16'h0000, regs[`SSP_ADDR_FOT_LEN]} + `SSP_FOT_EXTRA) * `SSP_LINE_CYCLES;
  assign read_cycles = {8'h00, regs[`SSP_ADDR_LINES_HI], regs[`SSP_ADDR_LINES_LO]}
                       * `SSP_LINE_CYCLES;

  ssp_state_t state;
  ssp_state_t next_state;
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic [15:0] frames_left;
  logic [15:0] next_frames_left;
  wire cnt_last;
  assign cnt_last = cnt <= 24'h000001;

  // requests while busy are ignored
  always_comb
  begin
    next_state = state;
    next_cnt = cnt - 24'h000001;
    next_frames_left = frames_left;
    case (state)
      SSP_IDLE:
      begin
        next_cnt = cnt;
        if (frame_req_s)
        begin
          next_state = SSP_EXPOSE;
          next_cnt = exp_cycles;
          next_frames_left = frames_total;
        end
      end
      SSP_EXPOSE:
      begin
        if (cnt_last)
        begin
          next_state = SSP_FOT;
          next_cnt = fot_cycles;
        end
      end
      SSP_FOT:
      begin
        if (cnt_last)
        begin
          next_state = SSP_READ;
          next_cnt = read_cycles;
        end
      end
      SSP_READ:
      begin
        if (cnt_last)
        begin
          if (frames_left <= 16'h0001)
          begin
            next_state = SSP_IDLE;
            next_cnt = 24'h000000;
            next_frames_left = 16'h0000;
          end
          else
          begin
            next_state = SSP_EXPOSE;
            next_cnt = exp_cycles;
            next_frames_left = frames_left - 16'h0001;
          end
        end
      end
      default:
      begin
        next_state = SSP_IDLE;
        next_cnt = 24'h000000;
        next_frames_left = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reg_hold)
    begin
      state <= SSP_IDLE;
      cnt <= 24'h000000;
      frames_left <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      frames_left <= next_frames_left;
    end
  end

  assign busy_o = state != SSP_IDLE;
  assign fot_o = state == SSP_FOT;
  assign readout_o = state == SSP_READ;

  default clocking ssp_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  reset_defaults_a: assert property (
    $fell(rst_n_s) |=> (adc_gain_o == `SSP_GAIN_DEFAULT && !busy_o))
    else $error("reset edge did not restore defaults");

  gain_default_a: assert property (
    $fell(rst_i) |-> (adc_gain_o == `SSP_GAIN_DEFAULT))
    else $error("adc gain not 32 after reset");

  write_store_a: assert property (
    (wr_evt && !reg_hold) |=> (regs[$past(wr_addr)] == $past(wr_data)))
    else $error("written byte not stored");

  frame_start_a: assert property (
    (state == SSP_IDLE && frame_req_s && !reg_hold) |=> (state == SSP_EXPOSE))
    else $error("frame request not taken");

  idle_hold_a: assert property (
    (state == SSP_IDLE && !frame_req_s) |=> (state == SSP_IDLE))
    else $error("sequencer left idle without request");

  fot_length_a: assert property (
    $rose(fot_o) |-> fot_o [*8])
    else $error("overhead interval too short");

  reset_hold_a: assert property (
    !rst_n_s |=> (state == SSP_IDLE && frames_left == 16'h0000))
    else $error("sequencer ran while reset low");

  burst_end_a: assert property (
    (state == SSP_READ && cnt_last && frames_left == 16'h0001 && rst_n_s)
    |=> (state == SSP_IDLE) ##1 !busy_o)
    else $error("sequencer did not stop after last frame");

  sync_delay_a: assert property (
    (rst_n_s && $fell(sync_q1[0])) |=> !rst_n_s)
    else $error("reset pin not seen two edges later");

endmodule : ssp_top

/* tb/ssp_host_model.sv */
// host controller model that drives the serial control port
`timescale 1ns/1ps
module ssp_host_model (
  output logic spi_clk_o,
  output logic spi_en_o,
  output logic spi_in_o,
  input wire logic spi_out_i
);
  initial
  begin
    spi_clk_o = 1'b0;
    spi_en_o = 1'b0;
    spi_in_o = 1'b0;
  end

  // one bit every 80 ns; the clock stands low between frames
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] din,
    input int nbits, input logic last, output logic [7:0] dout);
    logic [15:0] word;
    word = {wr, addr, din};
    dout = 8'h00;
    spi_en_o = 1'b1;
    for (int i = 0; i < nbits; i++)
    begin
      spi_in_o = word[15 - i];
      #40 spi_clk_o = 1'b1;
      if (i > 7)
        dout[15 - i] = spi_out_i;
      #40 spi_clk_o = 1'b0;
    end
    if (last)
    begin
      // released data line shows the inverse of the last bit
      spi_in_o = ~spi_in_o;
      if (nbits == 16)
      begin
        #40 spi_clk_o = 1'b1;
        #40 spi_clk_o = 1'b0;
      end
      #40 spi_en_o = 1'b0;
    end
  endtask : xfer

  // stray clock and data activity while enable is low
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++)
    begin
      spi_in_o = ~spi_in_o;
      #40 spi_clk_o = 1'b1;
      #40 spi_clk_o = 1'b0;
    end
  endtask : idle_clocks
endmodule : ssp_host_model

/* tb/test_sensor_spi_control_port.sv */
// self-checking bench of the sensor serial control port
`timescale 1ns/1ps
module test_sensor_spi_control_port;
  import ssp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic sensor_reset_n_i = 1'b0;
  logic frame_req_i = 1'b0;
  logic spi_clk_i;
  logic spi_en_i;
  logic spi_in_i;
  logic spi_out_o;
  logic busy_o;
  logic fot_o;
  logic readout_o;
  ssp_byte_t adc_gain_o;
  ssp_byte_t v1;
  ssp_byte_t v2;
  logic saw_r;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #12.5 clk_i = ~clk_i;

  ssp_top ssp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .sensor_reset_n_i(sensor_reset_n_i),
    .frame_req_i(frame_req_i), .spi_clk_i(spi_clk_i), .spi_en_i(spi_en_i),
    .spi_in_i(spi_in_i), .spi_out_o(spi_out_o), .busy_o(busy_o), .fot_o(fot_o),
    .readout_o(readout_o), .adc_gain_o(adc_gain_o));

  ssp_host_model ssp_host_model_inst (.spi_clk_o(spi_clk_i), .spi_en_o(spi_en_i),
    .spi_in_o(spi_in_i), .spi_out_i(spi_out_o));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    ssp_byte_t unused;
    ssp_host_model_inst.xfer(1'b1, a, d, 16, 1'b1, unused);
    tick(8);
  endtask : wr

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    ssp_byte_t v;
    ssp_host_model_inst.xfer(1'b0, a, 8'h00, 16, 1'b1, v);
    check(what, exp, v);
    tick(2);
  endtask : rd_chk

  task automatic pulse_req();
    frame_req_i = 1'b1;
    tick(2);
    frame_req_i = 1'b0;
  endtask : pulse_req

  task automatic t_defaults();
    check("gain", 8'h20, adc_gain_o);
    check("busy", 8'h00, {7'h00, busy_o});
    rd_chk("fot len", 7'h49, 8'h14);
    rd_chk("lines hi", 7'h02, 8'h08);
  endtask : t_defaults

  task automatic t_write();
    wr(7'h76, 8'ha5);
    check("gain wr", 8'ha5, adc_gain_o);
    rd_chk("gain rd", 7'h76, 8'ha5);
    check("out idle", 8'h00, {7'h00, spi_out_o});
    wr(7'h72, 8'h01);
    wr(7'h74, 8'h01);
    rd_chk("clk range a", 7'h72, 8'h01);
    rd_chk("clk range b", 7'h74, 8'h01);
  endtask : t_write

  task automatic t_burst();
    ssp_host_model_inst.xfer(1'b1, 7'h4e, 8'h3c, 16, 1'b0, v1);
    ssp_host_model_inst.xfer(1'b1, 7'h4f, 8'hc3, 16, 1'b0, v1);
    ssp_host_model_inst.xfer(1'b0, 7'h4e, 8'h00, 16, 1'b0, v1);
    ssp_host_model_inst.xfer(1'b0, 7'h4f, 8'h00, 16, 1'b1, v2);
    check("burst a", 8'h3c, v1);
    check("burst b", 8'hc3, v2);
    tick(2);
    ssp_host_model_inst.xfer(1'b0, 7'h7e, 8'h00, 16, 1'b0, v1);
    ssp_host_model_inst.xfer(1'b0, 7'h7f, 8'h00, 16, 1'b1, v2);
    check("temp lo", 8'h00, v1);
    check("temp hi", 8'h00, v2);
    tick(4);
  endtask : t_burst

  task automatic t_abort();
    ssp_host_model_inst.xfer(1'b1, 7'h76, 8'h11, 10, 1'b1, v1);
    ssp_host_model_inst.idle_clocks(4);
    tick(8);
    check("gain kept", 8'ha5, adc_gain_o);
    rd_chk("gain after abort", 7'h76, 8'ha5);
  endtask : t_abort

  task automatic t_sreset();
    sensor_reset_n_i = 1'b0;
    tick(4);
    sensor_reset_n_i = 1'b1;
    tick(40);
    check("gain reset", 8'h20, adc_gain_o);
    rd_chk("reg reset", 7'h4e, 8'h00);
  endtask : t_sreset

  task automatic t_frame();
    wr(7'h01, 8'h01);
    wr(7'h02, 8'h00);
    wr(7'h2a, 8'h04);
    wr(7'h2b, 8'h00);
    wr(7'h49, 8'h00);
    pulse_req();
    tick(2);
    check("busy start", 8'h01, {7'h00, busy_o});
    tick(8);
    check("fot", 8'h01, {7'h00, fot_o});
    pulse_req();
    wr(7'h4e, 8'h5a);
    check("busy kept", 8'h01, {7'h00, busy_o});
    saw_r = 1'b0;
    for (int i = 0; i < 3000 && busy_o === 1'b1; i++)
    begin
      tick(1);
      if (readout_o === 1'b1)
        saw_r = 1'b1;
    end
    check("readout seen", 8'h01, {7'h00, saw_r});
    tick(4);
    check("idle", 8'h00, {7'h00, busy_o});
    rd_chk("reg 78", 7'h4e, 8'h5a);
  endtask : t_frame

  initial
  begin
    #1;
    rst_i = 1'b1;
    tick(10);
    rst_i = 1'b0;
    sensor_reset_n_i = 1'b1;
    tick(40);
    t_defaults();
    t_write();
    t_burst();
    t_abort();
    t_sreset();
    t_frame();
    stop_test();
  end
endmodule : test_sensor_spi_control_port
